// ===== design/lwb_pkg.sv
// shared constants, types and helpers for the lpddr write burst path
// Operation
// - every write command carries bank, start column and a per-command auto-close choice.
// - with auto-close chosen, the written row is closed once the burst completes. The code closes no row for a burst that a following write runs on from.
// - precharge-select bit low beside a write means no auto-close for that access.
// - a byte is stored only when its byte mask was sampled low.
// - first element on first rising strobe edge, then one per strobe edge.
// - a burst completes after postamble plus write recovery and write-to-read delay.
// - after a burst, data lines stay undriven and further input data is ignored.
// - a new write may come on any clock rise; its data follows without a gap.
// - a read cuts the burst; only pairs captured before it are stored. The code also stores the element taken on the cutting clock edge.
// - a precharge to the same bank cuts the burst; later data is not stored.
// - each strobe qualifies its own byte lane, lane n covering data bits 8n+7:8n.
// - each byte mask governs its own byte lane, lane n covering bits 8n+7:8n.
// - burst lengths 2, 4, 8, 16; columns follow the programmed burst order.
// - writes may target any bank, back to back or spaced, without restriction.
package lwb_pkg;
    // register bus shape
    localparam int         REG_AW     = 8;
    localparam int         REG_DW     = 32;
    localparam logic [7:0] REG_CONFIG = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT  = 8'h08;

    // config field layout and value after reset
    localparam int          CFG_W       = 12;
    localparam int          CFG_BL_LSB  = 0;
    localparam int          CFG_ILV_BIT = 2;
    localparam int          CFG_WR_LSB  = 4;
    localparam int          CFG_WTR_LSB = 8;
    localparam logic [11:0] CFG_RESET   = 12'h221;

    // status bit positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DATA_BIT = 1;
    localparam int STAT_AP_BIT   = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_WTR_BIT  = 4;
    localparam int STAT_ELEM_LSB = 8;

    // command codes as {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_PRE   = 4'h2;
    localparam int         PRE_SEL_BIT = 10;

    // counter widths and saturation values
    localparam int              ELEM_W  = 5;
    localparam int              CYC_W   = 6;
    localparam int              REC_W   = 4;
    localparam int              CNT_W   = 16;
    localparam logic [5:0]      CYC_MAX = 6'h3F;
    localparam logic [3:0]      REC_MAX = 4'hF;

    typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_DATA, ST_RECOVER} lwb_state_e;

    // elements in a burst from the two-bit length code
    function automatic logic [ELEM_W-1:0] burst_len(input logic [1:0] code);
        return 5'h02 << code;
    endfunction : burst_len
endpackage : lwb_pkg

// ===== design/lwb_sync.sv
// two flip-flop synchroniser for pins arriving from outside the core clock
module lwb_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    // raw and synchronised levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    import lwb_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } lwb_sync_s;

    lwb_sync_s q;
    lwb_sync_s next_q;

    // meta stage feeds only the stable stage
    always_comb begin
        next_q.meta   = d_i;
        next_q.stable = q.meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign q_o = q.stable;
endmodule : lwb_sync

// ===== design/lwb_write_path.sv
// write burst capture, truncation and recovery tracking of the low-power ddr device
//
// The address map and the address-and-strobe port were decided locally.
module lwb_write_path #(
    parameter int LANES  = 2,
    parameter int COL_W  = 10,
    parameter int ADDR_W = 13
) (
    // core clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    // register port
    input  wire logic [lwb_pkg::REG_AW-1:0] reg_addr_i,
    input  wire logic [lwb_pkg::REG_DW-1:0] reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [lwb_pkg::REG_DW-1:0] reg_rdata_o,
    // command pins
    input  wire logic                       ck_i,
    input  wire logic                       cs_n_i,
    input  wire logic                       ras_n_i,
    input  wire logic                       cas_n_i,
    input  wire logic                       we_n_i,
    input  wire logic [1:0]                 bank_i,
    input  wire logic [ADDR_W-1:0]          addr_i,
    // data pins
    input  wire logic [LANES-1:0]           lane_strobe_i,
    input  wire logic [LANES-1:0]           write_byte_mask_i,
    input  wire logic [8*LANES-1:0]         dq_i,
    output logic      [8*LANES-1:0]         dq_o,
    output logic                            dq_oe_o,
    // array write port
    output logic                            arr_we_o,
    output logic      [1:0]                 arr_bank_o,
    output logic      [COL_W-1:0]           arr_col_o,
    output logic      [8*LANES-1:0]         arr_data_o,
    output logic      [LANES-1:0]           arr_byte_we_o,
    // completion and row closing
    output logic                            burst_done_o,
    output logic                            row_close_o,
    output logic      [1:0]                 row_close_bank_o
);
    import lwb_pkg::*;

    // refuse shapes the lane and column logic cannot serve
    if (!(LANES == 2 || LANES == 4) || COL_W < 4 || COL_W > PRE_SEL_BIT || ADDR_W <= PRE_SEL_BIT) begin : g_bad
        $error("lwb_write_path: unsupported LANES, COL_W or ADDR_W");
    end

    localparam int SW = 5 + 2 + ADDR_W + 10 * LANES;

    typedef struct packed {
        lwb_state_e           st;
        logic                 ck_d;
        logic [LANES-1:0]     stb_d;
        logic [LANES-1:0]     lane_on;
        logic [LANES-1:0]     got;
        logic [8*LANES-1:0]   hold_data;
        logic [LANES-1:0]     hold_mask;
        logic [1:0]           bank;
        logic [COL_W-1:0]     col;
        logic                 ap;
        logic [ELEM_W-1:0]    elem;
        logic [CYC_W-1:0]     cyc;
        logic                 pend;
        logic [1:0]           pend_bank;
        logic [COL_W-1:0]     pend_col;
        logic                 pend_ap;
        logic [CYC_W:0]       pend_at;
        logic [REC_W-1:0]     rec;
        logic                 arr_we;
        logic [1:0]           arr_bank;
        logic [COL_W-1:0]     arr_col;
        logic [8*LANES-1:0]   arr_data;
        logic [LANES-1:0]     arr_be;
        logic                 close;
        logic [1:0]           close_bank;
        logic                 done;
        logic [CFG_W-1:0]     cfg;
        logic [CNT_W-1:0]     count;
        logic [REG_DW-1:0]    rdata;
    } lwb_core_s;

    lwb_core_s q;
    lwb_core_s next_q;

    logic [SW-1:0]        sync_q;
    logic                 s_ck;
    logic [3:0]           s_cmd;
    logic [1:0]           s_bank;
    logic [ADDR_W-1:0]    s_addr;
    logic [LANES-1:0]     s_stb;
    logic [8*LANES-1:0]   s_dq;
    logic [LANES-1:0]     s_mask;
    logic                 ck_rise;
    logic [LANES-1:0]     edge_ok;
    logic                 capturing;
    logic                 trunc_cmd;
    logic [1:0]           bl_code;
    logic [CYC_W:0]       blen_ext;
    logic [REC_W-1:0]     wr_need;
    logic [REC_W-1:0]     wtr_need;
    logic [REG_DW-1:0]    status_word;

    // column of element idx in sequential or interleaved order within the burst span
    function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0]  start,
                                                   input logic [ELEM_W-1:0] idx,
                                                   input logic [1:0]        code,
                                                   input logic              ilv);
        logic [COL_W-1:0] span;
        logic [COL_W-1:0] ofs;
        span = COL_W'(burst_len(code)) - 1'b1;
        ofs  = ilv ? (start ^ COL_W'(idx)) : (start + COL_W'(idx));
        return (start & ~span) | (ofs & span);
    endfunction : burst_col

    // every pin crosses two flops; command, address, strobes and data stay aligned
    lwb_sync #(
        .W (SW)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .d_i        ({ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_i, addr_i,
                      lane_strobe_i, dq_i, write_byte_mask_i}),
        .q_o        (sync_q)
    );

    assign {s_ck, s_cmd, s_bank, s_addr, s_stb, s_dq, s_mask} = sync_q;

    // commands are taken on the rising edge of the memory clock
    assign ck_rise   = s_ck & ~q.ck_d;
    assign capturing = (q.st == ST_PRE) || (q.st == ST_DATA);
    // a lane waits for a rising edge first, then takes both edges
    assign edge_ok   = (q.lane_on & (s_stb ^ q.stb_d)) | (~q.lane_on & s_stb & ~q.stb_d);
    // read, or precharge to this bank or to all banks, cuts the burst
    assign trunc_cmd = (s_cmd == CMD_READ) ||
                       ((s_cmd == CMD_PRE) && (s_addr[PRE_SEL_BIT] || (s_bank == q.bank)));
    assign bl_code   = q.cfg[CFG_BL_LSB +: 2];
    assign blen_ext  = {2'b00, burst_len(bl_code)};
    assign wr_need   = q.cfg[CFG_WR_LSB +: REC_W];
    assign wtr_need  = q.cfg[CFG_WTR_LSB +: REC_W];

    // status word seen by software
    always_comb begin
        status_word                                 = '0;
        status_word[STAT_BUSY_BIT]                  = (q.st != ST_IDLE);
        status_word[STAT_DATA_BIT]                  = (q.st == ST_DATA);
        status_word[STAT_AP_BIT]                    = q.ap;
        status_word[STAT_PEND_BIT]                  = q.pend;
        status_word[STAT_WTR_BIT]                   = (q.st == ST_RECOVER) && (q.rec >= wtr_need);
        status_word[STAT_ELEM_LSB +: ELEM_W]        = q.elem;
    end

    // next state: register port, lane capture, element write, clock-edge work
    always_comb begin
        next_q        = q;
        next_q.arr_we = 1'b0;
        next_q.arr_be = '0;
        next_q.close  = 1'b0;
        next_q.done   = 1'b0;
        next_q.rdata  = '0;
        next_q.ck_d   = s_ck;
        next_q.stb_d  = s_stb;

        // register writes come first so a stored element wins over a count clear
        if (reg_wr_i) begin
            if (reg_addr_i == REG_CONFIG) begin
                next_q.cfg = reg_wdata_i[CFG_W-1:0];
            end else if (reg_addr_i == REG_COUNT) begin
                next_q.count = '0;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == REG_CONFIG) begin
                next_q.rdata = {{(REG_DW-CFG_W){1'b0}}, q.cfg};
            end else if (reg_addr_i == REG_STATUS) begin
                next_q.rdata = status_word;
            end else if (reg_addr_i == REG_COUNT) begin
                next_q.rdata = {{(REG_DW-CNT_W){1'b0}}, q.count};
            end else begin
                next_q.rdata = '0;
            end
        end

        // each lane latches its own byte and mask on its own strobe
        for (int l = 0; l < LANES; l++) begin
            if (capturing && edge_ok[l]) begin
                next_q.hold_data[8*l +: 8] = s_dq[8*l +: 8];
                next_q.hold_mask[l]        = s_mask[l];
                next_q.got[l]              = 1'b1;
                next_q.lane_on[l]          = 1'b1;
            end
        end

        // all lanes in: one element to the array at its burst-order column
        if (capturing && (&next_q.got)) begin
            next_q.got      = '0;
            next_q.arr_we   = 1'b1;
            next_q.arr_bank = q.bank;
            next_q.arr_col  = burst_col(q.col, q.elem, bl_code, q.cfg[CFG_ILV_BIT]);
            next_q.arr_data = next_q.hold_data;
            next_q.arr_be   = ~next_q.hold_mask; // masked bytes left untouched
            next_q.count    = next_q.count + 1'b1;
            next_q.elem     = q.elem + 1'b1;
            next_q.st       = ST_DATA;
            if (q.pend && (q.pend_at <= blen_ext) && ({2'b00, next_q.elem} == q.pend_at)) begin
                // next write's data runs on with no gap, truncating or concatenating
                next_q.bank = q.pend_bank;
                next_q.col  = q.pend_col;
                next_q.ap   = q.pend_ap;
                next_q.elem = '0;
                next_q.cyc  = q.cyc - q.pend_at[CYC_W:1];
                next_q.pend = 1'b0;
            end else if ({2'b00, next_q.elem} == blen_ext) begin
                // last element taken; postamble follows, recovery counts from here
                next_q.st  = ST_RECOVER;
                next_q.rec = '0;
            end
        end

        // memory-clock edge: count recovery and elapsed cycles
        if (ck_rise) begin
            if (next_q.st == ST_RECOVER && next_q.rec != REC_MAX) begin
                next_q.rec = next_q.rec + 1'b1;
            end
            if (next_q.cyc != CYC_MAX) begin
                next_q.cyc = next_q.cyc + 1'b1;
            end
        end

        // burst complete once both delays are met, or a new write takes over the path
        if (q.st == ST_RECOVER &&
            ((next_q.rec >= wr_need && next_q.rec >= wtr_need) || (ck_rise && s_cmd == CMD_WRITE))) begin
            next_q.done       = 1'b1;
            next_q.close      = q.ap; // row closed without a precharge command
            next_q.close_bank = q.bank;
            next_q.st         = ST_IDLE;
            if (q.pend) begin
                // a spaced write brings its own preamble
                next_q.st      = ST_PRE;
                next_q.bank    = q.pend_bank;
                next_q.col     = q.pend_col;
                next_q.ap      = q.pend_ap;
                next_q.elem    = '0;
                next_q.cyc     = next_q.cyc - q.pend_at[CYC_W:1];
                next_q.pend    = 1'b0;
                next_q.lane_on = '0;
                next_q.got     = '0;
            end
        end

        // commands; any bank is accepted with no spacing rule here
        if (ck_rise && s_cmd == CMD_WRITE) begin
            if (next_q.st == ST_PRE || next_q.st == ST_DATA) begin
                // data boundary is two elements per clock since the running write
                next_q.pend      = 1'b1;
                next_q.pend_bank = s_bank;
                next_q.pend_col  = s_addr[COL_W-1:0];
                next_q.pend_ap   = s_addr[PRE_SEL_BIT];
                next_q.pend_at   = {next_q.cyc, 1'b0};
            end else begin
                // bank, column and auto-close taken with the command
                next_q.st      = ST_PRE;
                next_q.bank    = s_bank;
                next_q.col     = s_addr[COL_W-1:0];
                next_q.ap      = s_addr[PRE_SEL_BIT];
                next_q.elem    = '0;
                next_q.cyc     = '0;
                next_q.lane_on = '0;
                next_q.got     = '0;
            end
        end else if (ck_rise && trunc_cmd && capturing) begin
            // nothing after the cut is stored; masked strobes still arriving are ignored
            next_q.st   = ST_RECOVER;
            next_q.rec  = '0;
            next_q.pend = 1'b0;
            next_q.got  = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q     <= '0;
            q.st  <= ST_IDLE;
            q.cfg <= CFG_RESET;
        end else begin
            q <= next_q;
        end
    end

    // this path never drives the data lines
    assign dq_o             = '0;
    assign dq_oe_o          = 1'b0;
    assign reg_rdata_o      = q.rdata;
    assign arr_we_o         = q.arr_we;
    assign arr_bank_o       = q.arr_bank;
    assign arr_col_o        = q.arr_col;
    assign arr_data_o       = q.arr_data;
    assign arr_byte_we_o    = q.arr_be;
    assign burst_done_o     = q.done;
    assign row_close_o      = q.close;
    assign row_close_bank_o = q.close_bank;

    // checks on the write path
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_write_idle;
        ck_rise && (s_cmd == CMD_WRITE) && (q.st == ST_IDLE);
    endsequence

    sequence s_pre_to_data;
        (q.st == ST_PRE) ##1 (q.st == ST_DATA);
    endsequence

    sequence s_cut_burst;
        ck_rise && trunc_cmd && (s_cmd != CMD_WRITE) && capturing;
    endsequence

    a_write_opens_burst: assert property (s_write_idle |=> (q.st == ST_PRE) && (q.elem == '0))
        else $error("write command did not open a burst");
    a_first_elem_stored: assert property (s_pre_to_data |-> q.arr_we)
        else $error("burst entered data phase without storing an element");
    a_cut_stops_store: assert property (s_cut_burst |=> (q.st == ST_RECOVER) && !q.pend ##1 !q.arr_we)
        else $error("read or precharge did not cut the burst");
    a_idle_no_store: assert property ((q.st == ST_IDLE) |=> !q.arr_we)
        else $error("element stored while idle");
    a_lines_undriven: assert property (!dq_oe_o)
        else $error("data lines driven by write path");
    a_no_stray_enable: assert property (!q.arr_we |-> (q.arr_be == '0))
        else $error("byte enable without array write");
    a_count_step: assert property (q.arr_we |-> q.count == ($past(reg_wr_i && (reg_addr_i == REG_COUNT)) ?
                                   16'h0001 : $past(q.count) + 16'h0001))
        else $error("stored element count did not step");
    a_done_recovered: assert property (burst_done_o && !$past(ck_rise && (s_cmd == CMD_WRITE)) |->
                                       ($past(q.st) == ST_RECOVER) && ($past(q.rec) + 4'h1 >= wr_need ||
                                        $past(q.rec) >= wr_need))
        else $error("burst completed before recovery");
    a_close_with_done: assert property (row_close_o |-> burst_done_o && (row_close_bank_o == $past(q.bank)))
        else $error("row closed outside burst completion");
    a_elem_in_burst: assert property (capturing |-> ({2'b00, q.elem} <= blen_ext))
        else $error("element index past burst length");
endmodule : lwb_write_path

// ===== verification/lwb_ctl_model.sv
// controller-side model driving the command, strobe, mask and data pins
module lwb_ctl_model (
    // memory clock and command pins as {cs_n, ras_n, cas_n, we_n}
    output logic        ck_o,
    output logic [3:0]  cmd_o,
    output logic [1:0]  bank_o,
    output logic [12:0] addr_o,
    // data pins
    output logic [1:0]  strobe_o,
    output logic [1:0]  mask_o,
    output logic [15:0] dq_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // free-running memory clock, offset so no pin moves on a core edge
    initial begin
        {cmd_o, bank_o, addr_o, strobe_o, mask_o, dq_o} = {4'hF, 2'h0, 13'h0000, 2'h0, 2'h3, 16'h0000};
        ck_o = 1'b0;
        #2;
        forever #40 ck_o = ~ck_o;
    end

    // one command held over a single ck rise, idle again at the next fall
    task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        @(negedge ck_o);
        {cmd_o, bank_o, addr_o} = {c, b, a};
        @(negedge ck_o);
        cmd_o = 4'hF;
    endtask : issue

    // one burst: command, preamble, first rise one ck after command, then every edge
    task automatic write_burst(input logic [1:0] b, input logic [9:0] c, input logic ap, input int n,
                               input logic [15:0] d [16], input logic [1:0] m [16]);
        issue(lwb_pkg::CMD_WRITE, b, {2'h0, ap, c});
        for (int k = 0; k < n; k++) begin
            #20 {dq_o, mask_o} = {d[k], m[k]};
            #20 strobe_o = ~strobe_o;
        end
        // strobe rests low; released lines flip so stale data never looks valid
        #20 {dq_o, mask_o} = ~{dq_o, mask_o};
    endtask : write_burst
endmodule : lwb_ctl_model

// ===== verification/lwb_write_path_tb.sv
// self-checking bench for the write burst path
module lwb_write_path_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lwb_pkg::*;

    logic        core_clk_i, rst_i, reg_wr, reg_rd, rd_d, ck, oe, arr_we, done, close;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0]  cmd;
    logic [1:0]  bank, strobe, mask, arr_bank, arr_byte_we, close_bank;
    logic [12:0] addr;
    logic [15:0] dq, dq_out, arr_data;
    logic [9:0]  arr_col;
    logic [29:0] exp_e;
    logic [2:0]  exp_d;
    int          num_errors, n_compared, seed;
    logic [29:0] q_elem [$];
    logic [2:0]  q_done [$];
    logic [31:0] q_reg [$];

    lwb_ctl_model ctl (.ck_o(ck), .cmd_o(cmd), .bank_o(bank), .addr_o(addr), .strobe_o(strobe), .mask_o(mask),
                       .dq_o(dq));
    lwb_write_path DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .ck_i(ck), .cs_n_i(cmd[3]),
        .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_i(bank), .addr_i(addr), .lane_strobe_i(strobe),
        .write_byte_mask_i(mask), .dq_i(dq), .dq_o(dq_out), .dq_oe_o(oe), .arr_we_o(arr_we),
        .arr_bank_o(arr_bank), .arr_col_o(arr_col), .arr_data_o(arr_data), .arr_byte_we_o(arr_byte_we),
        .burst_done_o(done), .row_close_o(close), .row_close_bank_o(close_bank));

    // 200 MHz core clock
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report

    // each result is compared with the oldest note of its kind
    always @(posedge core_clk_i) begin
        if (rd_d) check("reg_rdata", q_reg.pop_front(), reg_rdata);
        rd_d <= reg_rd;
        if (arr_we) begin
            check("arr_we_expected", 32'h1, 32'(q_elem.size() > 0));
            exp_e = q_elem.pop_front();
            check("arr_bank", 32'(exp_e[29:28]), 32'(arr_bank));
            check("arr_col", 32'(exp_e[27:18]), 32'(arr_col));
            check("arr_data", 32'(exp_e[17:2]), 32'(arr_data));
            check("arr_byte_we", 32'(exp_e[1:0]), 32'(arr_byte_we));
        end
        if (done) begin
            exp_d = q_done.pop_front();
            check("row_close", 32'(exp_d[2]), 32'(close));
            if (exp_d[2]) check("close_bank", 32'(exp_d[1:0]), 32'(close_bank));
            check("dq_oe", 32'h0, 32'(oe));
            check("dq_out", 32'h0, 32'(dq_out));
        end
    end

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        q_reg.push_back(exp);
        @(posedge core_clk_i);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
    endtask : reg_read

    // wait for every element and completion note to be met, so the next command sees a finished burst
    task automatic drain;
        for (int i = 0; i < 4000 && q_elem.size() + q_done.size() > 0; i++) @(posedge core_clk_i);
        repeat (4) @(posedge core_clk_i);
    endtask : drain

    // random burst; masks never hide both lanes, so every element is stored
    task automatic burst(input logic [1:0] code, input logic ilv, input logic ap);
        logic [15:0] d [16];
        logic [1:0]  m [16];
        logic [9:0]  c, msk;
        logic [1:0]  b;
        int          n;
        n = 2 << code;
        msk = 10'((2 << code) - 1);
        c = 10'($random(seed));
        b = 2'($random(seed));
        for (int k = 0; k < n; k++) begin
            d[k] = 16'($random(seed));
            m[k] = 2'($random(seed));
            if (m[k] == 2'h3) m[k] = 2'h1;
            q_elem.push_back({b, ilv ? c ^ 10'(k) : (c & ~msk) | ((c + 10'(k)) & msk), d[k], ~m[k]});
        end
        q_done.push_back({ap, b});
        ctl.write_burst(b, c, ap, n, d, m);
        drain();
    endtask : burst

    // second command two clocks after a write of four: a write runs on, a read or precharge cuts
    task automatic follow(input logic [3:0] how);
        logic [15:0] d [16];
        logic [1:0]  m [16];
        logic [9:0]  c [2];
        logic [1:0]  b [2];
        int          n;
        n = (how == CMD_WRITE) ? 8 : 4;
        for (int h = 0; h < 2; h++) begin
            c[h] = 10'($random(seed));
            b[h] = 2'($random(seed));
        end
        // the element on the cutting command's edge is still taken, so the controller masks it
        for (int k = 0; k < n; k++) begin
            d[k] = 16'($random(seed));
            m[k] = (n == 4 && k >= 2) ? 2'h3 : 2'($random(seed));
            if (n == 8 || k < 3) begin
                q_elem.push_back({b[k/4], c[k/4][9:2], 2'(c[k/4][1:0] + k), d[k], ~m[k]});
            end
        end
        q_done.push_back({1'b0, b[n/8]});
        fork
            ctl.write_burst(b[0], c[0], 1'b0, n, d, m);
            begin
                repeat (2) @(negedge ck);
                ctl.issue(how, b[n/8], {3'h0, c[1]});
            end
        join
        drain();
    endtask : follow

    initial begin
        seed = 32'hf9a9;
        num_errors = 0;
        n_compared = 0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, rst_i} = {8'h00, 32'h0, 1'b0, 1'b0, 1'b1};
        repeat (8) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        reg_read(REG_CONFIG, 32'h221);
        reg_read(REG_COUNT, 32'h0);
        reg_read(8'h0C, 32'h0);
        reg_read(REG_STATUS, 32'h0);
        // every burst length, odd codes interleaved, short ones auto-closing
        for (int code = 0; code < 4; code++) begin
            reg_write(REG_CONFIG, 32'h220 | 32'(code) | (32'(code & 1) << CFG_ILV_BIT));
            burst(2'(code), 1'(code & 1), 1'(code < 2));
        end
        reg_write(REG_CONFIG, 32'h221);
        follow(CMD_READ);
        follow(CMD_WRITE);
        follow(CMD_PRE);
        reg_read(REG_COUNT, 32'h2C);
        reg_write(REG_COUNT, 32'h0);
        reg_read(REG_COUNT, 32'h0);
        repeat (4) @(posedge core_clk_i);
        check("notes_left", 32'h0, 32'(q_elem.size() + q_done.size() + q_reg.size()));
        final_report;
    end

    // whole run needs well under this span
    initial begin
        #100000;
        num_errors++;
        final_report;
    end
endmodule : lwb_write_path_tb
